// >>> pkg/dphy_stim_consts.vh
// Constants for the stimulus output control block
`ifndef DPHY_STIM_CONSTS_VH
`define DPHY_STIM_CONSTS_VH

// ----------------------------------------------------------------
// Timing parameter indices
// ----------------------------------------------------------------
`define TP_COUNT      4'hC
`define TP_LAST       4'hB
`define TP_CLK_POST   4'h0
`define TP_CLK_PRE    4'h1
`define TP_CLK_PREP   4'h2
`define TP_CLK_TRAIL  4'h3
`define TP_CLK_ZERO   4'h4
`define TP_HS_EXIT    4'h5
`define TP_HS_PREP    4'h6
`define TP_HIGHSPEED_ZERO_PERIOD    4'h7
`define TP_HS_TRAIL   4'h8
`define TP_LPX        4'h9
`define TP_TA_GET     4'hA
`define TP_TA_GO      4'hB

// ----------------------------------------------------------------
// Timing reset values in ns
// ----------------------------------------------------------------
`define TPD_CLK_POST  10'h181
`define TPD_CLK_PRE   10'h050
`define TPD_CLK_PREP  10'h028
`define TPD_CLK_TRAIL 10'h03C
`define TPD_CLK_ZERO  10'h118
`define TPD_HS_EXIT   10'h064
`define TPD_HS_PREP   10'h04B
`define TPD_HIGHSPEED_ZERO_PERIOD   10'h0A0
`define TPD_HS_TRAIL  10'h02D
`define TPD_LPX       10'h032
`define TPD_TA_GET    10'h096
`define TPD_TA_GO     10'h096

// ----------------------------------------------------------------
// Step sizes
// ----------------------------------------------------------------
`define STEP_NS       13'h0005
`define UI_PER_NS_K   13'h03E8
`define STEP_UI_LEAD  13'h0002
`define STEP_UI_ZERO  13'h0008

// ----------------------------------------------------------------
// Target sense threshold in mV
// ----------------------------------------------------------------
`define THRESH_RESET  12'h4B0
`define THRESH_MIN    12'h320
`define THRESH_MAX    12'hCE4

// ----------------------------------------------------------------
// Reference clock measurement
// ----------------------------------------------------------------
`define CORE_PERIOD_NS   5
`define REF_RATIO        10
`define MEAS_WINDOW_NS   10000
`define MEAS_WINDOW_CYC  (`MEAS_WINDOW_NS / `CORE_PERIOD_NS)
`define MEAS_LAST_CYC    11'h7CF

`endif

// >>> hw/stim_fifo.v
// Word FIFO with a registered output stage
`default_nettype none

module stim_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   localparam [AW:0] FULL_CNT = DEPTH[AW:0];

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_ff;
   reg  [AW-1:0]    rd_ptr_ff;
   reg  [AW:0]      cnt_ff;
   reg              out_valid_ff;
   reg  [WIDTH-1:0] out_data_ff;
   wire             push;
   wire             load;

   assign in_ready  = (cnt_ff != FULL_CNT);
   assign push      = in_valid & in_ready;
   assign load      = (cnt_ff != {(AW+1){1'b0}}) & (~out_valid_ff | out_ready);
   assign out_valid = out_valid_ff;
   assign out_data  = out_data_ff;

   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_ff] <= in_data;
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_ff    <= {AW{1'b0}};
         rd_ptr_ff    <= {AW{1'b0}};
         cnt_ff       <= {(AW+1){1'b0}};
         out_valid_ff <= 1'b0;
         out_data_ff  <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         if (load)
         begin
            rd_ptr_ff    <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            out_data_ff  <= mem[rd_ptr_ff];
            out_valid_ff <= 1'b1;
         end
         else if (out_ready)
            out_valid_ff <= 1'b0;
         case ({push, load})
            2'b10:   cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
            2'b01:   cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
            default: cnt_ff <= cnt_ff;
         endcase
      end
   end

endmodule

`default_nettype wire

// >>> hw/dphy_stimulus_output_control.v
// Output gating, timing steps, rate measurement and special frames of the D-PHY stimulus source
//
// Function
// - Lane drivers stay disabled while output drive enable is off.
// - Drive only with enable on, target powered and settings applied.
// - Disabled lanes are high impedance and all six lights show off.
// - An override input bypasses the target power sense qualification.
// - Sense threshold clamps to 800..3300 mV, resets to 1200 mV.
// - Loss of target power stops lane driving.
// - Timing values reset to specification compliant defaults.
// - Most timing parameters use 5 ns steps.
// - Round up; clock lead 2 UI steps, clock and Highspeed_zero_period 8 UI.
// - Four two-word special frames inserted into stream, optional payload CRC.
`include "dphy_stim_consts.vh"
`default_nettype none

module dphy_stimulus_output_control (
   // Clock and reset
   input  wire        CORE_CLK,
   input  wire        RESET_N,
   // Output enable control
   input  wire        OUTPUT_DRIVE_ENABLE,
   input  wire        IGNORE_SENSE,
   input  wire        APPLY,
   input  wire [11:0] VSENSE_MV,
   input  wire [11:0] THRESH_MV,
   input  wire        THRESH_WR,
   output wire [5:0]  LANE_OE_N,
   output wire [5:0]  LANE_LED_OFF,
   output wire        SETTINGS_APPLIED,
   output wire [11:0] THRESH_Q,
   // Reference clock
   input  wire        REF_CLK,
   output wire [10:0] LANE_RATE_MBPS,
   // Timing parameters
   input  wire [3:0]  TIMING_SEL,
   input  wire [9:0]  TIMING_NS,
   input  wire        TIMING_WR,
   input  wire [3:0]  TIMING_RD_SEL,
   output wire [10:0] TIMING_STEPS,
   output wire        CONV_BUSY,
   // Special frames
   input  wire [2:0]  FRAME_ADDR,
   input  wire [31:0] FRAME_DATA,
   input  wire        FRAME_WR,
   input  wire        CRC_ENABLE,
   input  wire        FRAME_INSERT,
   output wire        INSERT_BUSY,
   // Stimulus word stream
   output wire [31:0] STREAM_DATA,
   output wire        STREAM_VALID,
   input  wire        STREAM_READY
);

   localparam [2:0] C_IDLE = 3'b001;
   localparam [2:0] C_LOAD = 3'b010;
   localparam [2:0] C_DIV  = 3'b100;
   localparam [2:0] F_IDLE = 3'b001;
   localparam [2:0] F_WORD = 3'b010;
   localparam [2:0] F_CRC  = 3'b100;
   localparam [10:0] WIN_LAST = `MEAS_LAST_CYC;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function [9:0] tp_default;
      input [3:0] idx;
      begin
         case (idx)
            `TP_CLK_POST:  tp_default = `TPD_CLK_POST;
            `TP_CLK_PRE:   tp_default = `TPD_CLK_PRE;
            `TP_CLK_PREP:  tp_default = `TPD_CLK_PREP;
            `TP_CLK_TRAIL: tp_default = `TPD_CLK_TRAIL;
            `TP_CLK_ZERO:  tp_default = `TPD_CLK_ZERO;
            `TP_HS_EXIT:   tp_default = `TPD_HS_EXIT;
            `TP_HS_PREP:   tp_default = `TPD_HS_PREP;
            `TP_HIGHSPEED_ZERO_PERIOD:   tp_default = `TPD_HIGHSPEED_ZERO_PERIOD;
            `TP_HS_TRAIL:  tp_default = `TPD_HS_TRAIL;
            `TP_LPX:       tp_default = `TPD_LPX;
            `TP_TA_GET:    tp_default = `TPD_TA_GET;
            default:       tp_default = `TPD_TA_GO;
         endcase
      end
   endfunction

   // Reflected CCITT CRC, byte 0 first, LSB first
   function [15:0] crc16_word;
      input [15:0] c;
      input [31:0] d;
      integer      k;
      reg   [15:0] r;
      begin
         r = c;
         for (k = 0; k < 32; k = k + 1)
            r = (r[0] ^ d[k]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
         crc16_word = r;
      end
   endfunction

   // ----------------------------------------------------------------
   // Reference clock rate measurement
   // ----------------------------------------------------------------
   reg         ref_s1_ff;
   reg         ref_s2_ff;
   reg         ref_s3_ff;
   reg  [10:0] win_ff;
   reg  [10:0] edges_ff;
   reg  [10:0] rate_ff;
   reg         rate_chg_ff;
   wire        ref_rise = ref_s2_ff & ~ref_s3_ff;
   wire [10:0] nxt_edges = edges_ff + {10'h000, ref_rise};

   // Edges in a 10 us window equal the reference MHz times the ratio of 10, which is the rate in Mbps
   always @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         ref_s1_ff   <= 1'b0;
         ref_s2_ff   <= 1'b0;
         ref_s3_ff   <= 1'b0;
         win_ff      <= 11'h000;
         edges_ff    <= 11'h000;
         rate_ff     <= 11'h000;
         rate_chg_ff <= 1'b0;
      end
      else
      begin
         ref_s1_ff   <= REF_CLK;
         ref_s2_ff   <= ref_s1_ff;
         ref_s3_ff   <= ref_s2_ff;
         rate_chg_ff <= 1'b0;
         if (win_ff == WIN_LAST)
         begin
            win_ff      <= 11'h000;
            edges_ff    <= 11'h000;
            rate_ff     <= nxt_edges;
            rate_chg_ff <= (nxt_edges != rate_ff);
         end
         else
         begin
            win_ff   <= win_ff + 11'h001;
            edges_ff <= nxt_edges;
         end
      end
   end

   // ----------------------------------------------------------------
   // Timing storage and step conversion
   // ----------------------------------------------------------------
   reg  [9:0]  tns_ff [0:11];
   reg  [10:0] tstep_ff [0:11];
   reg  [2:0]  cst_ff;
   reg  [3:0]  cidx_ff;
   reg  [20:0] rem_ff;
   reg  [12:0] dvs_ff;
   reg  [10:0] q_ff;
   reg         restart_ff;
   reg         applied_ff;
   reg  [10:0] rd_steps_ff;
   reg  [11:0] thresh_ff;
   reg         conv_busy_ff;
   wire        c_idle   = (cst_ff == C_IDLE);
   wire        tw_ok    = TIMING_WR & c_idle & (TIMING_SEL < `TP_COUNT);
   wire        th_ok    = THRESH_WR & c_idle;
   wire        start    = c_idle & (APPLY | (rate_chg_ff & applied_ff));
   wire        div_end  = (cst_ff == C_DIV) & (rem_ff == 21'h000000);
   // A rate change on the last step reruns instead of finishing
   wire        finish   = div_end & (cidx_ff == `TP_LAST) & ~restart_ff & ~rate_chg_ff;
   wire        c_to_idle = c_idle ? ~start : finish;
   wire        ui_lead  = (cidx_ff == `TP_CLK_PRE);
   wire        ui_zero  = (cidx_ff == `TP_CLK_ZERO) | (cidx_ff == `TP_HIGHSPEED_ZERO_PERIOD);
   wire [20:0] ns_rate  = tns_ff[cidx_ff] * rate_ff;
   integer     i;

   always @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         for (i = 0; i < 12; i = i + 1)
         begin
            tns_ff[i]   <= tp_default(i[3:0]);
            tstep_ff[i] <= 11'h000;
         end
         cst_ff      <= C_IDLE;
         cidx_ff     <= 4'h0;
         rem_ff      <= 21'h000000;
         dvs_ff      <= 13'h0000;
         q_ff        <= 11'h000;
         restart_ff  <= 1'b0;
         rd_steps_ff <= 11'h000;
         conv_busy_ff <= 1'b0;
      end
      else
      begin
         rd_steps_ff <= (TIMING_RD_SEL < `TP_COUNT) ? tstep_ff[TIMING_RD_SEL] : 11'h000;
         conv_busy_ff <= ~c_to_idle;
         if (tw_ok)
            tns_ff[TIMING_SEL] <= TIMING_NS;
         if (rate_chg_ff & ~c_idle)
            restart_ff <= 1'b1;
         case (cst_ff)
            C_IDLE:
            begin
               cidx_ff <= 4'h0;
               if (start)
                  cst_ff <= C_LOAD;
            end
            C_LOAD:
            begin
               q_ff <= 11'h000;
               if (ui_lead)
               begin
                  rem_ff <= ns_rate;
                  dvs_ff <= `STEP_UI_LEAD * `UI_PER_NS_K;
               end
               else if (ui_zero)
               begin
                  rem_ff <= ns_rate;
                  dvs_ff <= `STEP_UI_ZERO * `UI_PER_NS_K;
               end
               else
               begin
                  rem_ff <= {11'h000, tns_ff[cidx_ff]};
                  dvs_ff <= `STEP_NS;
               end
               cst_ff <= C_DIV;
            end
            C_DIV:
            begin
               if (div_end)
               begin
                  // Never less than one step
                  tstep_ff[cidx_ff] <= (q_ff == 11'h000) ? 11'h001 : q_ff;
                  if (cidx_ff != `TP_LAST)
                  begin
                     cidx_ff <= cidx_ff + 4'h1;
                     cst_ff  <= C_LOAD;
                  end
                  else if (restart_ff | rate_chg_ff)
                  begin
                     restart_ff <= 1'b0;
                     cidx_ff    <= 4'h0;
                     cst_ff     <= C_LOAD;
                  end
                  else
                     cst_ff <= C_IDLE;
               end
               else
               begin
                  // Partial step still counts a full step
                  rem_ff <= (rem_ff > {8'h00, dvs_ff}) ? rem_ff - {8'h00, dvs_ff} : 21'h000000;
                  q_ff   <= q_ff + 11'h001;
               end
            end
            default: cst_ff <= C_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output enable qualification
   // ----------------------------------------------------------------
   reg         sense_ok_ff;
   reg  [5:0]  oe_n_ff;
   reg  [5:0]  led_off_ff;
   wire        drive = OUTPUT_DRIVE_ENABLE & applied_ff &
                       (sense_ok_ff | IGNORE_SENSE);

   always @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         thresh_ff   <= `THRESH_RESET;
         applied_ff  <= 1'b0;
         sense_ok_ff <= 1'b0;
         oe_n_ff     <= 6'h3F;
         led_off_ff  <= 6'h3F;
      end
      else
      begin
         if (th_ok)
         begin
            if (THRESH_MV < `THRESH_MIN)
               thresh_ff <= `THRESH_MIN;
            else if (THRESH_MV > `THRESH_MAX)
               thresh_ff <= `THRESH_MAX;
            else
               thresh_ff <= THRESH_MV;
         end
         if (finish)
            applied_ff <= 1'b1;
         else if (start | tw_ok | th_ok)
            applied_ff <= 1'b0;
         sense_ok_ff <= (VSENSE_MV >= thresh_ff);
         oe_n_ff     <= drive ? 6'h00 : 6'h3F;
         led_off_ff  <= drive ? 6'h00 : 6'h3F;
      end
   end

   // ----------------------------------------------------------------
   // Special frames and insertion
   // ----------------------------------------------------------------
   reg  [31:0] frame_mem [0:7];
   reg  [2:0]  fst_ff;
   reg  [2:0]  fidx_ff;
   reg  [15:0] crc_ff;
   reg         crc_en_ff;
   reg         ins_busy_ff;
   integer     j;
   wire        f_idle   = (fst_ff == F_IDLE);
   wire        fifo_rdy;
   wire        fifo_vld = ~f_idle;
   wire        pushed   = fifo_vld & fifo_rdy;
   wire [31:0] cur_word = frame_mem[fidx_ff];
   wire [31:0] fifo_din = (fst_ff == F_CRC) ? {16'h0000, crc_ff} : cur_word;
   wire [15:0] crc_base = fidx_ff[0] ? crc_ff : 16'hFFFF;
   wire        f_to_idle = f_idle ? ~FRAME_INSERT : (pushed & (fidx_ff == 3'h7) & ((fst_ff == F_CRC) | ~crc_en_ff));

   always @(posedge CORE_CLK)
   begin
      if (!RESET_N)
      begin
         for (j = 0; j < 8; j = j + 1)
            frame_mem[j] <= 32'h00000000;
         fst_ff    <= F_IDLE;
         fidx_ff   <= 3'h0;
         crc_ff    <= 16'hFFFF;
         crc_en_ff <= 1'b0;
         ins_busy_ff <= 1'b0;
      end
      else
      begin
         ins_busy_ff <= ~f_to_idle;
         if (FRAME_WR & f_idle)
            frame_mem[FRAME_ADDR] <= FRAME_DATA;
         case (fst_ff)
            F_IDLE:
            begin
               fidx_ff <= 3'h0;
               if (FRAME_INSERT)
               begin
                  crc_en_ff <= CRC_ENABLE;
                  fst_ff    <= F_WORD;
               end
            end
            F_WORD:
               if (pushed)
               begin
                  crc_ff <= crc16_word(crc_base, cur_word);
                  if (!fidx_ff[0])
                     fidx_ff <= fidx_ff + 3'h1;
                  else if (crc_en_ff)
                     fst_ff <= F_CRC;
                  else if (fidx_ff == 3'h7)
                     fst_ff <= F_IDLE;
                  else
                     fidx_ff <= fidx_ff + 3'h1;
               end
            F_CRC:
               if (pushed)
               begin
                  if (fidx_ff == 3'h7)
                     fst_ff <= F_IDLE;
                  else
                  begin
                     fidx_ff <= fidx_ff + 3'h1;
                     fst_ff  <= F_WORD;
                  end
               end
            default: fst_ff <= F_IDLE;
         endcase
      end
   end

   stim_fifo #(
      .WIDTH (32),
      .DEPTH (8),
      .AW    (3)
   ) u_fifo (
      .clk       (CORE_CLK),
      .rst_n     (RESET_N),
      .in_valid  (fifo_vld),
      .in_ready  (fifo_rdy),
      .in_data   (fifo_din),
      .out_valid (STREAM_VALID),
      .out_ready (STREAM_READY),
      .out_data  (STREAM_DATA)
   );

   // ----------------------------------------------------------------
   // Output assignments
   // ----------------------------------------------------------------
   assign LANE_OE_N        = oe_n_ff;
   assign LANE_LED_OFF     = led_off_ff;
   assign SETTINGS_APPLIED = applied_ff;
   assign THRESH_Q         = thresh_ff;
   assign LANE_RATE_MBPS   = rate_ff;
   assign TIMING_STEPS     = rd_steps_ff;
   assign CONV_BUSY        = conv_busy_ff;
   assign INSERT_BUSY      = ins_busy_ff;

endmodule

`default_nettype wire

// >>> test/stim_output_props.sv
// Port checks for the stimulus output control block
`default_nettype none
module stim_output_props (
   // Clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESET_N,
   // Enable and settings
   input wire logic        OUTPUT_DRIVE_ENABLE,
   input wire logic        IGNORE_SENSE,
   input wire logic        APPLY,
   input wire logic        THRESH_WR,
   input wire logic [11:0] VSENSE_MV,
   input wire logic [3:0]  TIMING_SEL,
   input wire logic        TIMING_WR,
   // Lane state
   input wire logic [5:0]  LANE_OE_N,
   input wire logic [5:0]  LANE_LED_OFF,
   input wire logic        SETTINGS_APPLIED,
   input wire logic [11:0] THRESH_Q,
   input wire logic        CONV_BUSY,
   // Stream
   input wire logic [31:0] STREAM_DATA,
   input wire logic        STREAM_VALID,
   input wire logic        STREAM_READY
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);
   // --------
   // Steps
   // --------
   sequence power_lost;
      (VSENSE_MV < THRESH_Q && !IGNORE_SENSE) ##1 !IGNORE_SENSE;
   endsequence
   sequence settings_write;
      (APPLY || THRESH_WR || (TIMING_WR && TIMING_SEL < 4'hC)) && !CONV_BUSY;
   endsequence
   // --------
   // Checks
   // --------
   chk_lanes_off: assert property (!OUTPUT_DRIVE_ENABLE |=> LANE_OE_N == 6'h3F)
      else $error("lanes driven with drive enable off");
   chk_drive_needs_all: assert property (LANE_OE_N == 6'h00 |-> $past(OUTPUT_DRIVE_ENABLE) && $past(SETTINGS_APPLIED))
      else $error("lanes driven without enable and applied settings");
   chk_lanes_together: assert property (LANE_LED_OFF == LANE_OE_N && (LANE_OE_N == 6'h00 || LANE_OE_N == 6'h3F))
      else $error("lanes or lights split");
   chk_ignore_bypass: assert property (OUTPUT_DRIVE_ENABLE && SETTINGS_APPLIED && IGNORE_SENSE |=> LANE_OE_N == 6'h00)
      else $error("override did not enable lanes");
   chk_thresh_range: assert property (THRESH_Q >= 12'h320 && THRESH_Q <= 12'hCE4)
      else $error("threshold outside range");
   chk_sense_loss: assert property (power_lost |=> LANE_OE_N == 6'h3F)
      else $error("lanes still driven after power loss");
   chk_apply_busy: assert property (APPLY && !CONV_BUSY |=> CONV_BUSY && !SETTINGS_APPLIED)
      else $error("apply did not start conversion");
   chk_write_clears: assert property (settings_write |=> !SETTINGS_APPLIED)
      else $error("applied flag survived a settings write");
   chk_done_applies: assert property ($fell(CONV_BUSY) |-> SETTINGS_APPLIED)
      else $error("conversion ended without applied flag");
   chk_stream_hold: assert property (STREAM_VALID && !STREAM_READY |=> STREAM_VALID && $stable(STREAM_DATA))
      else $error("stream word dropped while stalled");
endmodule
bind dphy_stimulus_output_control stim_output_props u_props (.CORE_CLK, .RESET_N, .OUTPUT_DRIVE_ENABLE,
   .IGNORE_SENSE, .APPLY, .THRESH_WR, .VSENSE_MV, .TIMING_SEL, .TIMING_WR, .LANE_OE_N, .LANE_LED_OFF,
   .SETTINGS_APPLIED, .THRESH_Q, .CONV_BUSY, .STREAM_DATA, .STREAM_VALID, .STREAM_READY);
`default_nettype wire

// >>> test/stim_receiver_model.sv
// Far side model: target power sense, reference clock and stream acceptance
`default_nettype none
module stim_receiver_model (
   // Clock and reset
   input wire logic         clk,
   input wire logic         rst_n,
   // Bench control
   input wire logic         powered,
   input wire logic         slow,
   // Toward the block
   output logic [11:0]      vsense_mv,
   output var logic         ref_clk = 1'b0,
   output var logic         ready = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0]              pace_ff = 2'h0;
   // Sense level drops to ground when the target loses power
   assign vsense_mv = powered ? 12'h708 : 12'h000;
   // Free running at one tenth of an 80 Mbps lane, phase unrelated to the core
   initial
   begin
      #7.3;
      forever #62.5 ref_clk = ~ref_clk;
   end
   // Slow mode accepts one word in four
   always @(negedge clk)
   begin
      pace_ff <= rst_n ? pace_ff + 2'h1 : 2'h0;
      ready <= slow ? (pace_ff == 2'h3) : 1'b1;
   end
endmodule
`default_nettype wire

// >>> test/test_dphy_stimulus_output_control.sv
// Self-checking bench for the stimulus output control block
`include "dphy_stim_consts.vh"
`default_nettype none
module test_dphy_stimulus_output_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, ode = 1'b0, ign = 1'b0, apply = 1'b0, thr_wr = 1'b0, tm_wr = 1'b0;
   logic fr_wr = 1'b0, crc_en = 1'b0, ins = 1'b0, powered = 1'b1, slow = 1'b0;
   logic [11:0] thr = 12'h000;
   logic [3:0]  sel = 4'h0, rd_sel = 4'h0;
   logic [9:0]  tns = 10'h000;
   logic [2:0]  fa = 3'h0;
   logic [31:0] fd = 32'h0, r;
   wire  [11:0] vs, thr_q;
   wire  [10:0] rate, steps;
   wire  [5:0]  oe_n, led;
   wire  [31:0] s_data;
   wire         ref_clk, applied, busy, ibusy, s_valid, s_ready;
   int          n_errors = 0, comparisons = 0, seed = 93064;
   logic [31:0] exp_q[$], frm[8];
   logic [9:0]  ns_tab[12] = '{`TPD_CLK_POST, `TPD_CLK_PRE, `TPD_CLK_PREP, `TPD_CLK_TRAIL, `TPD_CLK_ZERO,
      `TPD_HS_EXIT, `TPD_HS_PREP, `TPD_HIGHSPEED_ZERO_PERIOD, `TPD_HS_TRAIL, `TPD_LPX, `TPD_TA_GET, `TPD_TA_GO};
   always #2.5 clk = ~clk;
   dphy_stimulus_output_control DUT (.CORE_CLK(clk), .RESET_N(rst_n), .OUTPUT_DRIVE_ENABLE(ode), .IGNORE_SENSE(ign),
      .APPLY(apply), .VSENSE_MV(vs), .THRESH_MV(thr), .THRESH_WR(thr_wr), .LANE_OE_N(oe_n), .LANE_LED_OFF(led),
      .SETTINGS_APPLIED(applied), .THRESH_Q(thr_q), .REF_CLK(ref_clk), .LANE_RATE_MBPS(rate), .TIMING_SEL(sel),
      .TIMING_NS(tns), .TIMING_WR(tm_wr), .TIMING_RD_SEL(rd_sel), .TIMING_STEPS(steps), .CONV_BUSY(busy),
      .FRAME_ADDR(fa), .FRAME_DATA(fd), .FRAME_WR(fr_wr), .CRC_ENABLE(crc_en), .FRAME_INSERT(ins),
      .INSERT_BUSY(ibusy), .STREAM_DATA(s_data), .STREAM_VALID(s_valid), .STREAM_READY(s_ready));
   stim_receiver_model u_peer (.clk(clk), .rst_n(rst_n), .powered(powered), .slow(slow), .vsense_mv(vs),
      .ref_clk(ref_clk), .ready(s_ready));
   // --------
   // Helpers
   // --------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [10:0] want_steps(input logic [3:0] s, input logic [9:0] v);
      logic [31:0] q;
      if (s == `TP_CLK_PRE)
         q = (v * 32'h50 + 32'h7CF) / 32'h7D0;
      else if (s == `TP_CLK_ZERO || s == `TP_HIGHSPEED_ZERO_PERIOD)
         q = (v * 32'h50 + 32'h1F3F) / 32'h1F40;
      else
         q = (v + 32'h4) / 32'h5;
      return (q == 32'h0) ? 11'h001 : q[10:0];
   endfunction
   function automatic logic [15:0] crc16(input logic [63:0] d);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 0; i < 64; i++)
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      return c;
   endfunction
   task put_timing(input logic [3:0] s, input logic [9:0] v);
      sel = s;
      tns = v;
      tm_wr = 1'b1;
      @(negedge clk);
      tm_wr = 1'b0;
      @(negedge clk);
   endtask
   task put_thresh(input logic [11:0] v, input logic [11:0] want);
      thr = v;
      thr_wr = 1'b1;
      @(negedge clk);
      thr_wr = 1'b0;
      check("threshold", thr_q, want);
      check("applied after write", applied, 1'b0);
   endtask
   task do_apply(input logic poke);
      apply = 1'b1;
      @(negedge clk);
      apply = 1'b0;
      if (poke)
         put_timing(4'h0, 10'h001);
      for (int i = 0; i < 5000 && busy !== 1'b0; i++)
         @(negedge clk);
      check("applied", applied, 1'b1);
   endtask
   task read_all;
      for (int s = 0; s < 12; s++)
      begin
         rd_sel = s[3:0];
         @(negedge clk);
         check("steps", steps, want_steps(s[3:0], ns_tab[s]));
      end
   endtask
   task expect_oe(input logic [5:0] v);
      repeat (4) @(negedge clk);
      check("lane enable", oe_n, v);
      check("lane lights", led, v);
   endtask
   task insert(input logic crc);
      for (int n = 0; n < 4; n++)
      begin
         exp_q.push_back(frm[2*n]);
         exp_q.push_back(frm[2*n+1]);
         if (crc)
            exp_q.push_back({16'h0000, crc16({frm[2*n+1], frm[2*n]})});
      end
      crc_en = crc;
      ins = 1'b1;
      @(negedge clk);
      ins = 1'b0;
      check("insert busy", ibusy, 1'b1);
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
         @(negedge clk);
      check("words left", exp_q.size(), 32'h0);
      check("insert idle", ibusy, 1'b0);
   endtask
   // --------
   // Stream monitor
   // --------
   always @(posedge clk)
      if (rst_n && s_valid === 1'b1 && s_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("extra word", s_data, 32'hXXXXXXXX);
         else
            check("stream word", s_data, exp_q.pop_front());
      end
   initial
   begin
      #300000;
      n_errors++;
      tally_and_finish;
   end
   // --------
   // Scenarios
   // --------
   initial
   begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("threshold reset", thr_q, 12'h4B0);
      check("valid reset", s_valid, 1'b0);
      ode = 1'b1;
      expect_oe(6'h3F);
      // Lane speed is measured before any conversion is asked
      repeat (4500) @(negedge clk);
      check("lane rate", rate, 11'h050);
      do_apply(1'b0);
      read_all;
      expect_oe(6'h00);
      powered = 1'b0;
      expect_oe(6'h3F);
      ign = 1'b1;
      expect_oe(6'h00);
      ign = 1'b0;
      powered = 1'b1;
      expect_oe(6'h00);
      ode = 1'b0;
      expect_oe(6'h3F);
      ode = 1'b1;
      put_thresh(12'hFFF, 12'hCE4);
      do_apply(1'b0);
      expect_oe(6'h3F);
      put_thresh(12'h000, 12'h320);
      do_apply(1'b0);
      expect_oe(6'h00);
      for (int k = 0; k < 12; k++)
      begin
         r = $random(seed);
         ns_tab[k] = r[9:0];
         put_timing(k[3:0], ns_tab[k]);
      end
      do_apply(1'b1);
      put_timing(4'hC, 10'h3FF);
      check("applied kept", applied, 1'b1);
      read_all;
      for (int a = 0; a < 8; a++)
      begin
         frm[a] = $random(seed);
         fa = a[2:0];
         fd = frm[a];
         fr_wr = 1'b1;
         @(negedge clk);
      end
      fr_wr = 1'b0;
      slow = 1'b1;
      insert(1'b1);
      slow = 1'b0;
      insert(1'b0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
